// file: logic/tsad_pkg.sv
// What this block does
// - Stimulus write port serves three masters: processor cluster, DMA, fabric bridge.
// - Window is 48 MB, three 16 MB segments at FC, FD, FE million hex.
// - Write address bits 7..0 pick the byte within a 256-byte stimulus port.
// - Write address bits 23..8 pick one of 65536 stimulus ports.
// - Address bits 25..24 pick the segment; only 0, 1, 2 are legal.
// - Every emitted stimulus message carries a source master identifier.
// - Source identifier bits 5..0 copy write address bits 29..24.
// - Source identifier bit 6 copies protection bit 1: 0 secure, 1 nonsecure.
// - Hardware events 31..4 come from the fabric cross trigger, each makes a message.
// - Debug reset clears every register of the trace-bus clock domain.
package tsad_pkg;
  localparam int NUM_MASTERS = 3;
  localparam int NUM_FABRIC_EVT = 28;
  localparam int EVT_BASE = 4;
  localparam logic [31:0] SEG_BASE_LO = 32'hFC000000;
  localparam logic [31:0] SEG_BASE_MID = 32'hFD000000;
  localparam logic [31:0] SEG_BASE_HI = 32'hFE000000;
  localparam logic [31:0] WIN_END = 32'hFEFFFFFF;
  localparam logic [5:0] WIN_TAG = 6'h3F;
  localparam logic [1:0] SEG_BAD = 2'h3;
  localparam int TAG_HI = 31;
  localparam int TAG_LO = 26;
  localparam int SRC_HI = 29;
  localparam int SEG_HI = 25;
  localparam int SEG_LO = 24;
  localparam int PORT_HI = 23;
  localparam int PORT_LO = 8;
  localparam int BYTE_HI = 7;
  localparam int BYTE_LO = 0;
  localparam int PROT_NS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Arbitrary neutral source identifier stamped on fabric event messages
  localparam logic [6:0] EVT_SRC_ID = 7'h7F;

  typedef enum logic {TSAD_KIND_STIM, TSAD_KIND_EVENT} tsad_kind_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] prot;
  } tsad_aw_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } tsad_w_t;

  typedef struct packed {
    tsad_kind_t kind;
    logic [6:0] srcId;
    logic [15:0] port;
    logic [7:0] byteOff;
    logic [31:0] data;
    logic [3:0] strb;
  } tsad_msg_t;
endpackage

// file: logic/tsad_stim_decode.sv
module tsad_stim_decode #(
  parameter int NumMasters = tsad_pkg::NUM_MASTERS,
  parameter int NumEvents = tsad_pkg::NUM_FABRIC_EVT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NumMasters-1:0] sAwValid,
  output logic [NumMasters-1:0] sAwReady,
  input wire tsad_pkg::tsad_aw_t sAw [NumMasters],
  input wire logic [NumMasters-1:0] sWValid,
  output logic [NumMasters-1:0] sWReady,
  input wire tsad_pkg::tsad_w_t sW [NumMasters],
  output logic [NumMasters-1:0] sBValid,
  input wire logic [NumMasters-1:0] sBReady,
  output logic [1:0] sBResp,
  input wire logic [NumEvents-1:0] fabricEvent,
  output logic msgValid,
  input wire logic msgReady,
  output tsad_pkg::tsad_msg_t msg
);
  localparam int GW = (NumMasters > 1) ? $clog2(NumMasters) : 1;
  localparam int EW = (NumEvents > 1) ? $clog2(NumEvents) : 1;

  typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_RESP} tsad_state_t;

  tsad_state_t state, next_state;
  logic [GW-1:0] grant, next_grant;
  logic [GW-1:0] rr, next_rr;
  tsad_pkg::tsad_aw_t aw, next_aw;
  tsad_pkg::tsad_w_t w, next_w;
  logic [1:0] resp, next_resp;
  logic msgFull, next_msgFull;
  tsad_pkg::tsad_msg_t next_msg;
  logic [NumEvents-1:0] pend, next_pend;
  logic [NumEvents-1:0] evtMeta, evtSync, evtPrev;
  logic [NumEvents-1:0] evtRise;
  logic reqHit;
  logic [GW-1:0] pick;
  logic slotFree;
  logic evtAny;
  logic [EW-1:0] evtIdx;

  // Fabric events are asynchronous: two flops, then edge detect on the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      evtMeta <= '0;
      evtSync <= '0;
      evtPrev <= '0;
    end
    else if (ce)
    begin
      evtMeta <= fabricEvent;
      evtSync <= evtMeta;
      evtPrev <= evtSync;
    end
  end

  assign evtRise = evtSync & ~evtPrev;
  assign slotFree = !msgFull || msgReady;
  assign msgValid = msgFull && ce;

  // Round-robin pick among masters offering both address and data
  always_comb
  begin
    int idx;
    idx = 0;
    reqHit = 1'b0;
    pick = '0;
    for (int k = 0; k < NumMasters; k++)
    begin
      idx = (int'(rr) + k) % NumMasters;
      if (!reqHit && sAwValid[idx] && sWValid[idx])
      begin
        reqHit = 1'b1;
        pick = GW'(idx);
      end
    end
  end

  // Lowest pending event goes first; higher numbers wait their turn
  always_comb
  begin
    evtAny = 1'b0;
    evtIdx = '0;
    for (int k = NumEvents - 1; k >= 0; k--)
    begin
      if (pend[k])
      begin
        evtAny = 1'b1;
        evtIdx = EW'(k);
      end
    end
  end

  // Handshake outputs; segment 3 writes are still accepted and answered
  generate
    for (genvar i = 0; i < NumMasters; i++)
    begin : g_master
      assign sAwReady[i] = ce && state == ST_IDLE && reqHit && pick == GW'(i);
      assign sWReady[i] = ce && state == ST_IDLE && reqHit && pick == GW'(i);
      assign sBValid[i] = ce && state == ST_RESP && grant == GW'(i);
    end
  endgenerate

  assign sBResp = resp;

  // Next state of the write path, the message slot and the event flags
  always_comb
  begin
    tsad_pkg::tsad_aw_t pa;
    logic [31:0] a;
    logic [NumEvents-1:0] clr;
    pa = sAw[pick];
    a = pa.addr;
    clr = '0;
    next_state = state;
    next_grant = grant;
    next_rr = rr;
    next_aw = aw;
    next_w = w;
    next_resp = resp;
    next_msgFull = msgFull && !msgReady;
    next_msg = msg;
    case (state)
      ST_IDLE:
      begin
        if (reqHit)
        begin
          next_grant = pick;
          next_aw = pa;
          next_w = sW[pick];
          next_rr = (int'(pick) == NumMasters - 1) ? '0 : GW'(int'(pick) + 1);
          if (a >= tsad_pkg::SEG_BASE_LO && a <= tsad_pkg::WIN_END)
          begin
            next_state = ST_EMIT;
            next_resp = tsad_pkg::RESP_OKAY;
          end
          else
          begin
            next_state = ST_RESP;
            // Only the unused segment of the window is answered OKAY
            if (a[tsad_pkg::TAG_HI:tsad_pkg::TAG_LO] == tsad_pkg::WIN_TAG)
              next_resp = tsad_pkg::RESP_OKAY;
            else
              next_resp = tsad_pkg::RESP_DECERR;
          end
        end
        else if (evtAny && slotFree)
        begin
          next_msgFull = 1'b1;
          next_msg.kind = tsad_pkg::TSAD_KIND_EVENT;
          next_msg.srcId = tsad_pkg::EVT_SRC_ID;
          next_msg.port = 16'(int'(evtIdx) + tsad_pkg::EVT_BASE);
          next_msg.byteOff = '0;
          next_msg.data = '0;
          next_msg.strb = '0;
          clr[evtIdx] = 1'b1;
        end
      end
      ST_EMIT:
      begin
        if (slotFree)
        begin
          next_msgFull = 1'b1;
          next_msg.kind = tsad_pkg::TSAD_KIND_STIM;
          next_msg.srcId = {aw.prot[tsad_pkg::PROT_NS],
                            aw.addr[tsad_pkg::SRC_HI:tsad_pkg::SEG_LO]};
          next_msg.port = aw.addr[tsad_pkg::PORT_HI:tsad_pkg::PORT_LO];
          next_msg.byteOff = aw.addr[tsad_pkg::BYTE_HI:tsad_pkg::BYTE_LO];
          next_msg.data = w.data;
          next_msg.strb = w.strb;
          next_state = ST_RESP;
        end
      end
      ST_RESP:
      begin
        if (sBReady[grant])
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
    // A new edge in the cycle its flag is taken keeps the flag set
    next_pend = (pend & ~clr) | evtRise;
  end

  // All state freezes while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      grant <= '0;
      rr <= '0;
      aw <= '0;
      w <= '0;
      resp <= tsad_pkg::RESP_OKAY;
      msgFull <= 1'b0;
      msg <= '0;
      pend <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      grant <= next_grant;
      rr <= next_rr;
      aw <= next_aw;
      w <= next_w;
      resp <= next_resp;
      msgFull <= next_msgFull;
      msg <= next_msg;
      pend <= next_pend;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_take;
    ce && state == ST_IDLE && reqHit;
  endsequence

  sequence s_emit;
    ce && state == ST_EMIT && slotFree;
  endsequence

  sequence s_badSeg;
    s_take ##0 sAw[pick].addr[tsad_pkg::TAG_HI:tsad_pkg::TAG_LO] == tsad_pkg::WIN_TAG
      ##0 sAw[pick].addr[tsad_pkg::SEG_HI:tsad_pkg::SEG_LO] == tsad_pkg::SEG_BAD;
  endsequence

  a_grant_one: assert property ($onehot0(sAwReady) && sAwReady == sWReady)
    else $error("more than one master granted");

  a_byte_select: assert property (s_emit |=> msg.byteOff == $past(aw.addr[7:0]))
    else $error("byte offset not taken from address bits 7..0");

  a_port_select: assert property (s_emit |=> msg.port == $past(aw.addr[23:8]))
    else $error("port not taken from address bits 23..8");

  a_legal_window: assert property (s_take ##1 state == ST_EMIT |->
    aw.addr >= tsad_pkg::SEG_BASE_LO && aw.addr <= tsad_pkg::WIN_END)
    else $error("write outside the window emitted");

  a_bad_segment: assert property (s_badSeg |=> state == ST_RESP
    && resp == tsad_pkg::RESP_OKAY ##1 !(msgFull && $rose(msgFull)))
    else $error("segment 3 write was not answered without message");

  a_resp_given: assert property (s_badSeg ##1 (ce && sBReady[grant]) |=>
    state == ST_IDLE)
    else $error("segment 3 write response did not complete");

  a_source_low: assert property (s_emit |=> msg.srcId[5:0] == $past(aw.addr[29:24]))
    else $error("source identifier low bits wrong");

  a_source_sec: assert property (s_emit |=> msg.srcId[6] == $past(aw.prot[1]))
    else $error("secure bit of source identifier wrong");

  // Held write fields only stay put until the next write is taken, so look while the response stands
  a_source_tag: assert property (msgFull && msg.kind == tsad_pkg::TSAD_KIND_STIM
    && state == ST_RESP |-> msg.srcId == {aw.prot[1], aw.addr[29:24]})
    else $error("stimulus message lost its source identifier");

  a_event_kept: assert property (ce && evtRise != '0 |=>
    (pend & $past(evtRise)) == $past(evtRise))
    else $error("fabric event edge was dropped");

  a_event_emit: assert property (ce && state == ST_IDLE && !reqHit && evtAny && slotFree
    |=> msgFull && msg.kind == tsad_pkg::TSAD_KIND_EVENT)
    else $error("pending event not emitted");

  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    state == ST_IDLE && !msgFull && pend == '0 && evtSync == '0)
    else $error("reset left state behind");
endmodule

// file: testbench/tsad_axi_masters.sv
module tsad_axi_masters (
  input wire logic clock,
  output logic [2:0] awValid,
  input wire logic [2:0] awReady,
  output tsad_pkg::tsad_aw_t aw [3],
  output logic [2:0] wValid,
  input wire logic [2:0] wReady,
  output tsad_pkg::tsad_w_t w [3],
  input wire logic [2:0] bValid,
  output logic [2:0] bReady,
  input wire logic [1:0] bResp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle masters present no request
  initial
  begin
    awValid = 3'h0;
    wValid = 3'h0;
    bReady = 3'h0;
    aw = '{default: '0};
    w = '{default: '0};
  end

  // One single-beat write; slow delays the response acceptance
  task automatic write(input int m, input logic [31:0] a, input logic [2:0] p,
    input logic [31:0] d, input int slow, output logic [1:0] resp, output bit ok);
    ok = 0;
    @(posedge clock);
    awValid[m] <= 1'b1;
    wValid[m] <= 1'b1;
    aw[m] <= '{a, p};
    w[m] <= '{d, 4'hF};
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clock);
      ok = awReady[m] && wReady[m];
    end
    awValid[m] <= 1'b0;
    wValid[m] <= 1'b0;
    // Released lines show the inverse, so a stale value cannot pass
    aw[m] <= '{~a, ~p};
    w[m] <= '{~d, 4'h0};
    repeat (slow) @(posedge clock);
    bReady[m] <= 1'b1;
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clock);
      ok = bValid[m];
    end
    resp = bResp;
    bReady[m] <= 1'b0;
  endtask
endmodule

// file: testbench/test_trace_stimulus_axi_decode.sv
module test_trace_stimulus_axi_decode;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic msgReady = 1'b0;
  logic ce = 1'b1;
  logic [27:0] fabricEvent = 28'h0;
  logic [2:0] awValid, awReady, wValid, wReady, bValid, bReady;
  logic [1:0] bResp;
  logic msgValid;
  tsad_pkg::tsad_aw_t aw [3];
  tsad_pkg::tsad_w_t w [3];
  tsad_pkg::tsad_msg_t msg;
  int n_mismatch = 0;
  int checked = 0;

  always #25 clock = ~clock;

  // Clock enable driven by the bench so that freezing can be exercised
  tsad_stim_decode uut (.clock(clock), .rst(rst), .ce(ce), .sAwValid(awValid),
    .sAwReady(awReady), .sAw(aw), .sWValid(wValid), .sWReady(wReady), .sW(w),
    .sBValid(bValid), .sBReady(bReady), .sBResp(bResp), .fabricEvent(fabricEvent),
    .msgValid(msgValid), .msgReady(msgReady), .msg(msg));

  tsad_axi_masters masters (.clock(clock), .awValid(awValid), .awReady(awReady), .aw(aw),
    .wValid(wValid), .wReady(wReady), .w(w), .bValid(bValid), .bReady(bReady), .bResp(bResp));

  task automatic chk(string what, logic [67:0] exp, logic [67:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Consume the message slot for one cycle, then expect it empty
  task automatic drain;
    @(posedge clock);
    msgReady <= 1'b1;
    @(posedge clock);
    msgReady <= 1'b0;
    @(posedge clock);
    #1 chk("slot empty", 0, msgValid);
  endtask

  task automatic do_write(int m, logic [31:0] a, logic p1, logic [31:0] d, logic [1:0] er,
    bit em, int slow);
    logic [1:0] r;
    bit ok;
    tsad_pkg::tsad_msg_t e;
    masters.write(m, a, {1'b0, p1, 1'b0}, d, slow, r, ok);
    chk("handshake", 1, ok);
    chk("resp", er, r);
    #1 chk("msgValid", em, msgValid);
    if (em)
    begin
      e = '{tsad_pkg::TSAD_KIND_STIM, {p1, a[29:24]}, a[23:8], a[7:0], d, 4'hF};
      chk("msg", e, msg);
      drain();
    end
  endtask

  task automatic t_reset;
    chk("reset bValid", 0, bValid);
    chk("reset msg", 0, {msgValid, msg});
  endtask

  // Each master keeps to its own segment, boundary ports and bytes
  task automatic t_segments;
    logic [31:0] tbl [3] = '{32'hFC000000, 32'hFDFFFFFF, 32'hFE123407};
    for (int m = 0; m < 3; m++)
      do_write(m, tbl[m], m[0], 32'hC0DE0000 + m, tsad_pkg::RESP_OKAY, 1, m);
  endtask

  task automatic t_seg3;
    do_write(0, 32'hFF000010, 1'b0, 32'h11, tsad_pkg::RESP_OKAY, 0, 0);
  endtask

  task automatic t_outside;
    do_write(1, 32'h7C000000, 1'b1, 32'h22, tsad_pkg::RESP_DECERR, 0, 2);
  endtask

  // Lowest and highest fabric event lines each give one message
  task automatic t_event;
    int idx [2] = '{0, 27};
    foreach (idx[k])
    begin
      @(posedge clock);
      fabricEvent[idx[k]] <= 1'b1;
      for (int i = 0; i < 20 && msgValid !== 1'b1; i++)
        @(posedge clock);
      #1 chk("event valid", 1, msgValid);
      chk("event kind", tsad_pkg::TSAD_KIND_EVENT, msg.kind);
      chk("event src", tsad_pkg::EVT_SRC_ID, msg.srcId);
      chk("event port", idx[k] + tsad_pkg::EVT_BASE, msg.port);
      @(posedge clock);
      fabricEvent[idx[k]] <= 1'b0;
      drain();
    end
  endtask

  // An event arriving while the enable is low must wait until it rises again
  task automatic t_freeze;
    @(posedge clock);
    ce <= 1'b0;
    fabricEvent[5] <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk("frozen valid", 0, msgValid);
    @(posedge clock);
    ce <= 1'b1;
    for (int i = 0; i < 20 && msgValid !== 1'b1; i++)
      @(posedge clock);
    #1 chk("thawed port", 5 + tsad_pkg::EVT_BASE, msg.port);
    @(posedge clock);
    fabricEvent[5] <= 1'b0;
    drain();
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    #1 t_reset();
    @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 t_reset();
    t_segments();
    t_seg3();
    t_outside();
    t_event();
    t_freeze();
    end_of_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
endmodule
